// *** clhc_core.sv ***
// Host register interface, address counter, RAMs and supply control.
// Operation
// - Two six-bit supply levels, char and icon
// - Zero level for active mode stops generator
// - Direct mode: generator off, supply tied
// - Bias levels follow multiplex rate
// - Frame tick every 3072 oscillator cycles
// - Reset finishes three cycles after release
// - Power-down stops oscillator, bias, outputs
// - Power-down keeps state, still runs commands
// - Command and data latches chosen by select
// - Command latch is write-only
// - Reads return data latch, then load it from RAM
// - Busy flag on bit 7, refuses commands
// - Counter loaded by address commands, steps
// - Counter shown on bits 6 to 0
// - Text RAM of 104 bytes, spare usable
// - Line one shows first 40 locations
// - Access wrap per display mode
// - Shift wrap stays within each line
// - Glyph ROM of 240 five-by-eight patterns
// - Select 0 command/status, 1 data
// - Transfer taken on strobe falling edge
// - Nibble mode uses bits 7 to 4
`default_nettype none
module clhc_core
  import clhc_pkg::*;
(
  input wire logic clock, // 50 MHz system clock
  input wire logic reset_n, // Async reset, active low
  input wire logic por_in, // External reset pin, active high
  input wire logic power_down_pin, // Power-down pin, active high
  input wire logic osc_clock_in, // Oscillator input pin
  input wire logic strobe_in, // Parallel bus strobe pin
  input wire logic reg_select, // Register select pin
  input wire logic read_not_write, // 1 read, 0 write
  input wire logic [7:0] host_bus_in, // Data lines in
  output logic [7:0] host_bus_out, // Data lines out
  output logic host_bus_oe, // High while driving data lines
  output logic frame_tick, // One-cycle frame pulse
  output logic generator_on, // Internal voltage generator running
  output logic supply_direct, // Output tied to second_logic_supply
  output logic [2:0] bias_levels, // Bias level count
  output logic lcd_outputs_grounded, // Drivers forced to ground
  output logic osc_enable, // Internal oscillator enable
  output logic [7:0] glyph_code, // Code at counter plus shift for glyph_rom
  output logic in_reset // Internal reset in progress
);
  logic [14:0] s1_q, s2_q;
  logic strobe_q, por_q, pd_q, osc_q, rs_q, rw_q;
  logic [7:0] bus_q;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 15'h0000;
      s2_q <= 15'h0000;
      strobe_q <= 1'b0;
      osc_q <= 1'b0;
      rs_q <= 1'b0;
      rw_q <= 1'b0;
      bus_q <= 8'h00;
    end
    else
    begin
      s1_q <= {host_bus_in, read_not_write, reg_select, por_in,
               power_down_pin, osc_clock_in, strobe_in, 1'b0};
      s2_q <= s1_q;
      strobe_q <= s2_q[1];
      osc_q <= s2_q[2];
      rs_q <= s2_q[5];
      rw_q <= s2_q[6];
      bus_q <= s2_q[14:7];
    end
  end
  assign por_q = s2_q[4];
  assign pd_q = s2_q[3];
  // Pins are held stable around the strobe, so one two-stage synchronizer serves all pins
  logic xfer, osc_edge;
  assign xfer = strobe_q && !s2_q[1];
  assign osc_edge = s2_q[2] && !osc_q;

  // Internal reset runs on oscillator edges after the pin drops
  logic [1:0] por_cnt_q, por_cnt_d;
  logic rst_q, rst_d;
  always_comb
  begin
    por_cnt_d = por_cnt_q;
    rst_d = rst_q;
    if (por_q)
    begin
      rst_d = 1'b1;
      por_cnt_d = 2'h0;
    end
    else if (rst_q && osc_edge)
    begin
      if (por_cnt_q == POR_SYNC_LAST)
        rst_d = 1'b0;
      else
        por_cnt_d = por_cnt_q + 2'h1;
    end
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      por_cnt_q <= 2'h0;
      rst_q <= 1'b1;
    end
    else
    begin
      por_cnt_q <= por_cnt_d;
      rst_q <= rst_d;
    end
  end
  assign in_reset = rst_q;

  // Frame divider counts oscillator edges; it stalls with the clock
  logic [11:0] div_q, div_d;
  logic tick_q, tick_d;
  always_comb
  begin
    div_d = div_q;
    tick_d = 1'b0;
    if (osc_edge)
    begin
      div_d = div_q == FRAME_DIV_LAST ? 12'h000 : div_q + 12'h001;
      tick_d = div_q == FRAME_DIV_LAST;
    end
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end
  assign frame_tick = tick_q;

  // Host-visible state
  logic [7:0] text_ram [0:103];
  logic [7:0] glyph_ram [0:63];
  logic [7:0] cmd_q, cmd_d, data_q, data_d;
  logic [6:0] ac_q, ac_d;
  logic glyph_sel_q, glyph_sel_d, up_q, up_d, nib_q, nib_d;
  logic half_q, half_d;
  logic [3:0] hi_q, hi_d, busy_q, busy_d;
  clhc_mode_t mode_q, mode_d;
  clhc_supply_t sup_q, sup_d;
  logic [6:0] shift_q, shift_d;
  logic wr_ram;
  logic [7:0] full, rd_word;
  logic whole, is_rd, is_wr;
  assign full = nib_q ? {hi_q, bus_q[7:4]} : bus_q;
  assign whole = !nib_q || half_q;
  assign is_wr = xfer && !rw_q && whole;
  assign is_rd = xfer && rw_q;
  assign rd_word = glyph_sel_q ? glyph_ram[ac_q[5:0]] : text_ram[ac_q];
  always_comb
  begin
    cmd_d = cmd_q;
    data_d = data_q;
    ac_d = ac_q;
    glyph_sel_d = glyph_sel_q;
    up_d = up_q;
    nib_d = nib_q;
    half_d = half_q;
    hi_d = hi_q;
    busy_d = busy_q == 4'h0 ? 4'h0 : busy_q - 4'h1;
    mode_d = mode_q;
    sup_d = sup_q;
    shift_d = shift_q;
    wr_ram = 1'b0;
    if (xfer && nib_q)
    begin
      half_d = !half_q;
      if (!half_q)
        hi_d = bus_q[7:4];
    end
    if (is_wr && !rs_q && busy_q == 4'h0)
    begin
      cmd_d = full;
      busy_d = BUSY_CYCLES;
      if (full[CMD_TEXT_ADDR_BIT])
      begin
        ac_d = full[6:0];
        glyph_sel_d = 1'b0;
      end
      else if (full[CMD_GLYPH_ADDR_BIT])
      begin
        ac_d = {1'b0, full[5:0]};
        glyph_sel_d = 1'b1;
      end
      else if (full[7:5] == 3'b010)
      begin
        if (full[7:4] == CMD_SUPPLY_ICON[7:4])
          sup_d.icon_level = 6'h00;
        else
          sup_d.char_level = 6'h00;
      end
      else if (full[CMD_FUNC_BIT])
      begin
        mode_d = clhc_mode_t'(full[1:0]);
        sup_d.direct_mode = full[FUNC_DIRECT_BIT];
        sup_d.icon_mode = full[FUNC_ICON_BIT];
        nib_d = full[FUNC_NIBBLE_BIT];
        half_d = 1'b0;
      end
      else if (full[CMD_SUPPLY_BIT])
      begin
        if (full == CMD_SHIFT_LEFT || full == CMD_SHIFT_RIGHT)
          shift_d = clhc_step(shift_q, full[2], mode_q, 1'b1);
      end
      else if (full[CMD_ENTRY_BIT])
        up_d = full[ENTRY_INC_BIT];
    end
    // Supply level writes go through the data latch after a supply prefix
    if (is_wr && rs_q)
    begin
      data_d = full;
      if (cmd_q[7:5] == 3'b010)
      begin
        if (cmd_q[4])
          sup_d.icon_level = full[5:0];
        else
          sup_d.char_level = full[5:0];
      end
      else
      begin
        wr_ram = 1'b1;
        ac_d = glyph_sel_q ? {1'b0, ac_q[5:0] + (up_q ? 6'h01 : 6'h3f)}
                           : clhc_step(ac_q, up_q, mode_q, 1'b0);
      end
    end
    if (is_rd && rs_q && whole)
    begin
      data_d = rd_word;
      ac_d = glyph_sel_q ? {1'b0, ac_q[5:0] + (up_q ? 6'h01 : 6'h3f)}
                         : clhc_step(ac_q, up_q, mode_q, 1'b0);
    end
    if (rst_q)
    begin
      ac_d = ADDR_ZERO;
      busy_d = 4'h0;
      up_d = 1'b1;
      nib_d = 1'b0;
      half_d = 1'b0;
      mode_d = CLHC_ONE_WIDE;
      shift_d = ADDR_ZERO;
      sup_d = '{SUPPLY_RESET, SUPPLY_RESET, 1'b0, 1'b0};
    end
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      ac_q <= ADDR_ZERO;
      glyph_sel_q <= 1'b0;
      up_q <= 1'b1;
      nib_q <= 1'b0;
      half_q <= 1'b0;
      hi_q <= 4'h0;
      busy_q <= 4'h0;
      mode_q <= CLHC_ONE_WIDE;
      sup_q <= '{SUPPLY_RESET, SUPPLY_RESET, 1'b0, 1'b0};
      shift_q <= ADDR_ZERO;
    end
    else
    begin
      cmd_q <= cmd_d;
      data_q <= data_d;
      ac_q <= ac_d;
      glyph_sel_q <= glyph_sel_d;
      up_q <= up_d;
      nib_q <= nib_d;
      half_q <= half_d;
      hi_q <= hi_d;
      busy_q <= busy_d;
      mode_q <= mode_d;
      sup_q <= sup_d;
      shift_q <= shift_d;
    end
  end
  // RAM contents are never cleared, so power-down keeps them
  always_ff @(posedge clock)
  begin
    if (wr_ram && glyph_sel_q)
      glyph_ram[ac_q[5:0]] <= full;
    else if (wr_ram && ac_q < TEXT_RAM_WORDS)
      text_ram[ac_q] <= full;
  end

  // Read path: status drives busy and counter, data the latch
  logic [7:0] rd_q, rd_d;
  logic oe_q, oe_d;
  always_comb
  begin
    rd_d = rd_q;
    oe_d = rw_q && strobe_q;
    if (!rs_q)
      rd_d = {busy_q != 4'h0, ac_q};
    else
      rd_d = data_q;
    if (nib_q && half_q)
      rd_d = {rd_d[3:0], 4'h0};
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end
  assign host_bus_out = rd_q;
  assign host_bus_oe = oe_q;

  // Supply, bias and power-down outputs
  logic [5:0] active_level;
  assign active_level = sup_q.icon_mode ? sup_q.icon_level
                                        : sup_q.char_level;
  assign generator_on = !pd_q && !sup_q.direct_mode
                        && active_level != SUPPLY_OFF;
  assign supply_direct = sup_q.direct_mode && !pd_q;
  assign bias_levels = pd_q ? 3'h0
                     : (mode_q == CLHC_ONE_SHORT && sup_q.icon_mode)
                       ? BIAS_FOUR : BIAS_FIVE;
  assign lcd_outputs_grounded = pd_q;
  assign osc_enable = !pd_q;
  assign glyph_code =
    text_ram[(ac_q + shift_q) % TEXT_RAM_WORDS];

  a_busy_refuse: assert property (@(posedge clock) disable iff (!reset_n)
    (is_wr && !rs_q && busy_q != 4'h0 && !rst_q) |=> cmd_q == $past(cmd_q))
    else $error("command taken while busy");
  a_busy_len: assert property (@(posedge clock) disable iff (!reset_n)
    (is_wr && !rs_q && busy_q == 4'h0 && !rst_q) |=> busy_q == 4'h4)
    else $error("busy not set on command");
  a_gen_off: assert property (@(posedge clock) disable iff (!reset_n)
    (sup_q.direct_mode || active_level == 6'h00) |-> !generator_on)
    else $error("generator on with zero level or direct");
  a_pd_ground: assert property (@(posedge clock) disable iff (!reset_n)
    pd_q |-> lcd_outputs_grounded && !osc_enable && !generator_on)
    else $error("power-down outputs wrong");
  a_wrap_two: assert property (@(posedge clock) disable iff (!reset_n)
    (is_wr && rs_q && !rst_q && !glyph_sel_q && cmd_q[7:5] != 3'b010
     && mode_q == CLHC_TWO_LINE && up_q && ac_q == 7'h27)
    |=> ac_q == 7'h40)
    else $error("two-line wrap wrong");
  a_frame_div: assert property (@(posedge clock) disable iff (!reset_n)
    (osc_edge && div_q == 12'hbff) |=> frame_tick)
    else $error("frame tick missing");
  a_status_read: assert property (@(posedge clock) disable iff (!reset_n)
    (!rs_q && !(nib_q && half_q)) |=> rd_q == {$past(busy_q) != 4'h0,
    $past(ac_q)})
    else $error("status read wrong");
  a_reset_len: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(por_q) |-> rst_q)
    else $error("internal reset ended early");
endmodule : clhc_core
`default_nettype wire

// *** clhc_host_model.sv ***
// Host microcontroller model driving the parallel register bus.
`default_nettype none
module clhc_host_model
(
  input wire logic clock, // System clock
  input wire logic [7:0] host_bus_out, // Device read data
  input wire logic host_bus_oe, // Device drives data lines
  output logic strobe_in, // Parallel strobe
  output logic reg_select, // Register select
  output logic read_not_write, // 1 read, 0 write
  output wire logic [7:0] host_bus_in // Resolved data lines
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_en;
  logic [7:0] drv_val;
  // Data lines have pull-ups, so a released bus reads all ones
  assign host_bus_in = host_bus_oe ? host_bus_out :
    (drv_en ? drv_val : 8'hff);
  initial
  begin
    strobe_in = 1'b0;
    reg_select = 1'b1;
    read_not_write = 1'b1;
    drv_en = 1'b0;
    drv_val = 8'h00;
  end
  // One strobe transfer; lines stay stable well around the falling edge
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] wd,
      output logic [7:0] rdv);
    @(posedge clock);
    #1;
    reg_select = rs;
    read_not_write = rd;
    drv_en = !rd;
    drv_val = wd;
    repeat (4) @(posedge clock);
    #1 strobe_in = 1'b1;
    repeat (8) @(posedge clock);
    #1 rdv = host_bus_in;
    strobe_in = 1'b0;
    repeat (6) @(posedge clock);
    #1 reg_select = 1'b1;
    read_not_write = 1'b1;
    drv_en = 1'b0;
    // Gap outlasts the busy time, so commands never collide
    repeat (6) @(posedge clock);
  endtask : xfer
endmodule : clhc_host_model
`default_nettype wire

// *** clhc_pkg.sv ***
// Constants and types shared by the character LCD host core.
`default_nettype none
package clhc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned FRAME_DIV = 3072;
  localparam logic [11:0] FRAME_DIV_LAST = 12'hbff;
  localparam int unsigned POR_SYNC_CYCLES = 3;
  localparam logic [1:0] POR_SYNC_LAST = 2'h2;
  localparam logic [5:0] SUPPLY_OFF = 6'h00;
  localparam logic [5:0] SUPPLY_RESET = 6'h00;
  localparam logic [6:0] TEXT_RAM_WORDS = 7'h68;
  localparam logic [6:0] LINE1_END = 7'h27;
  localparam logic [6:0] LINE2_START = 7'h40;
  localparam logic [6:0] LINE2_END = 7'h67;
  localparam logic [6:0] WIDE_END = 7'h4f;
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [5:0] GLYPH_RAM_LAST = 6'h3f;
  localparam int unsigned GLYPH_ROM_PATTERNS = 240;
  localparam logic [3:0] BUSY_CYCLES = 4'h4;
  localparam logic [2:0] BIAS_FIVE = 3'h5;
  localparam logic [2:0] BIAS_FOUR = 3'h4;
  // Command codes, decoded by leading one
  localparam int unsigned CMD_TEXT_ADDR_BIT = 7;
  localparam int unsigned CMD_GLYPH_ADDR_BIT = 6;
  localparam int unsigned CMD_FUNC_BIT = 5;
  localparam int unsigned CMD_SUPPLY_BIT = 4;
  localparam int unsigned CMD_ENTRY_BIT = 2;
  localparam int unsigned ENTRY_INC_BIT = 1;
  localparam int unsigned FUNC_DIRECT_BIT = 4;
  localparam int unsigned FUNC_ICON_BIT = 3;
  localparam int unsigned FUNC_NIBBLE_BIT = 2;
  localparam logic [7:0] CMD_SUPPLY_ICON = 8'h50;
  localparam logic [7:0] CMD_SUPPLY_CHAR = 8'h40;
  localparam logic [7:0] CMD_SHIFT_LEFT = 8'h18;
  localparam logic [7:0] CMD_SHIFT_RIGHT = 8'h1c;
  typedef enum logic [1:0] {
    CLHC_ONE_WIDE = 2'b00,
    CLHC_TWO_LINE = 2'b01,
    CLHC_ONE_SHORT = 2'b10
  } clhc_mode_t;
  typedef struct packed {
    logic [5:0] char_level;
    logic [5:0] icon_level;
    logic direct_mode;
    logic icon_mode;
  } clhc_supply_t;
  // Next address under access or shift wrap
  function automatic logic [6:0] clhc_step(input logic [6:0] a,
      input logic up, input clhc_mode_t m, input logic shift);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    case (m)
      CLHC_TWO_LINE:
      begin
        if (up && a == LINE1_END)
          r = shift ? ADDR_ZERO : LINE2_START;
        else if (up && a == LINE2_END)
          r = shift ? LINE2_START : ADDR_ZERO;
        else if (!up && a == ADDR_ZERO)
          r = shift ? LINE1_END : LINE2_END;
        else if (!up && a == LINE2_START)
          r = shift ? LINE2_END : LINE1_END;
      end
      CLHC_ONE_SHORT:
      begin
        if (up && a == LINE1_END)
          r = ADDR_ZERO;
        else if (!up && a == ADDR_ZERO)
          r = LINE1_END;
      end
      default:
      begin
        if (up && a == WIDE_END)
          r = ADDR_ZERO;
        else if (!up && a == ADDR_ZERO)
          r = WIDE_END;
      end
    endcase
    return r;
  endfunction : clhc_step
endpackage : clhc_pkg
`default_nettype wire

// *** test_char_lcd_host_core.sv ***
// Self-checking testbench for the character LCD host core.
`default_nettype none
module test_char_lcd_host_core;
  import clhc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic por_in = 1'b0;
  logic power_down_pin = 1'b0;
  logic osc_clock_in = 1'b0;
  logic strobe_in, reg_select, read_not_write;
  logic [7:0] host_bus_in, host_bus_out, glyph_code;
  logic host_bus_oe, frame_tick, generator_on, supply_direct;
  logic lcd_outputs_grounded, osc_enable, in_reset;
  logic [2:0] bias_levels;
  int err_total = 0;
  int check_count = 0;
  always #10 clock = ~clock;
  // Oscillator runs free, never stopped, not even in power-down
  always #80 osc_clock_in = ~osc_clock_in;
  clhc_core i_clhc_core (.clock(clock), .reset_n(reset_n), .por_in(por_in),
    .power_down_pin(power_down_pin), .osc_clock_in(osc_clock_in),
    .strobe_in(strobe_in), .reg_select(reg_select),
    .read_not_write(read_not_write), .host_bus_in(host_bus_in),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .frame_tick(frame_tick), .generator_on(generator_on),
    .supply_direct(supply_direct), .bias_levels(bias_levels),
    .lcd_outputs_grounded(lcd_outputs_grounded), .osc_enable(osc_enable),
    .glyph_code(glyph_code), .in_reset(in_reset));
  clhc_host_model i_clhc_host_model (.clock(clock),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .strobe_in(strobe_in), .reg_select(reg_select),
    .read_not_write(read_not_write), .host_bus_in(host_bus_in));
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic cmd(input logic [7:0] v);
    logic [7:0] x;
    i_clhc_host_model.xfer(1'b0, 1'b0, v, x);
  endtask : cmd
  task automatic dat(input logic [7:0] v);
    logic [7:0] x;
    i_clhc_host_model.xfer(1'b1, 1'b0, v, x);
  endtask : dat
  task automatic rd(input logic rs, output logic [7:0] v);
    i_clhc_host_model.xfer(rs, 1'b1, 8'h00, v);
  endtask : rd
  task automatic test_reset();
    repeat (10) @(posedge clock);
    #1 reset_n = 1'b1;
    check("in_reset", in_reset, 16'h1);
    por_in = 1'b1;
    repeat (20) @(posedge clock);
    @(posedge osc_clock_in);
    @(posedge clock);
    #1 por_in = 1'b0;
    repeat (2) @(posedge osc_clock_in);
    repeat (4) @(posedge clock);
    check("in_reset early", in_reset, 16'h1);
    @(posedge osc_clock_in);
    repeat (6) @(posedge clock);
    check("in_reset done", in_reset, 16'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_wrap();
    logic [7:0] fn [4] = '{8'h20, 8'h21, 8'h21, 8'h22};
    logic [7:0] st [4] = '{8'hcf, 8'ha7, 8'he7, 8'ha7};
    logic [7:0] ex [4] = '{8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      cmd(fn[i]);
      cmd(8'h06);
      cmd(st[i]);
      dat(8'h11);
      rd(1'b0, v);
      check("status", v, ex[i]);
    end
    $display("test wrap done");
  endtask : test_wrap
  task automatic test_ram();
    logic [7:0] v;
    cmd(8'h21);
    cmd(8'h06);
    cmd(8'ha7);
    dat(8'h5a);
    cmd(8'ha7);
    check("glyph_code", glyph_code, 16'h5a);
    rd(1'b1, v);
    rd(1'b1, v);
    check("read data", v, 16'h5a);
    rd(1'b0, v);
    check("counter", v, 16'h41);
    cmd(8'h04);
    cmd(8'h80);
    dat(8'h00);
    rd(1'b0, v);
    check("counter down", v, 16'h67);
    $display("test ram done");
  endtask : test_ram
  task automatic test_supply();
    cmd(CMD_SUPPLY_CHAR);
    dat(8'h3f);
    cmd(8'h20);
    check("gen char", {generator_on, supply_direct}, 16'h2);
    check("bias five", bias_levels, BIAS_FIVE);
    cmd(8'h2a);
    check("gen icon off", generator_on, 16'h0);
    check("bias four", bias_levels, BIAS_FOUR);
    cmd(CMD_SUPPLY_ICON);
    dat(8'h01);
    check("gen icon on", generator_on, 16'h1);
    cmd(8'h30);
    check("direct", {generator_on, supply_direct}, 16'h1);
    cmd(CMD_SUPPLY_CHAR);
    dat(8'h00);
    cmd(8'h20);
    check("gen char off", {generator_on, supply_direct}, 16'h0);
    $display("test supply done");
  endtask : test_supply
  task automatic test_frame();
    logic prev;
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
    end
    while (frame_tick !== 1'b1);
    prev = osc_clock_in;
    do
    begin
      @(posedge clock);
      #1;
      if (osc_clock_in && !prev)
        n++;
      prev = osc_clock_in;
    end
    while (frame_tick !== 1'b1);
    check("frame period", n[15:0], FRAME_DIV[15:0]);
    $display("test frame done");
  endtask : test_frame
  task automatic test_power_down();
    logic [7:0] v;
    @(posedge clock);
    #1 power_down_pin = 1'b1;
    repeat (4) @(posedge clock);
    check("pd state", {lcd_outputs_grounded, osc_enable}, 16'h2);
    cmd(8'h85);
    rd(1'b0, v);
    check("pd counter", v, 16'h05);
    #1 power_down_pin = 1'b0;
    repeat (4) @(posedge clock);
    check("run state", {lcd_outputs_grounded, osc_enable}, 16'h1);
    $display("test power down done");
  endtask : test_power_down
  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    final_report();
  end
  initial
  begin
    test_reset();
    test_wrap();
    test_ram();
    test_supply();
    test_power_down();
    test_frame();
    final_report();
  end
endmodule : test_char_lcd_host_core
`default_nettype wire
